/* File: dpp_post_proc.sv */
// Purpose: Playback post-processing ahead of a stereo sigma-delta DAC.
// Assumes: Upstream sends one stereo sample per period; APB zero-wait slave.
// Notes:   Applied gain codes travel beside each sample to the modulator.
// Operation
// - Mute ramps gain down step by step
// - Soft-silence bit resets to one
// - Unmute ramp off: gain jumps back
// - Unmute ramp on: gain ramps up
// - Speed bit: two or thirty-two periods
// - Full ramp fits 10.7 or 171 ms
// - Two-bit de-emphasis select, reset none
// - Mono sum halves left plus right
// - Polarity bits invert each channel
// - Filter bit selects sloped stopband
// - Datapath carries 24-bit samples
// - Six output enables, reset disabled
// - Each enable aliased at bit fifteen
// - Gain codes apply only on strobe
// - Gain code 0xc0 is reset value
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

module dpp_fifo
	import dpp_pkg::*;
#(
	parameter int WIDTH = 48,
	parameter int DEPTH = 32
)(
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// Fill side.
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side.
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// Full and empty come from the occupancy count, so neither can lie.
	assign inReady  = (count != DEPTH[AW:0]);
	assign outValid = (count != '0);
	assign outData  = store[rdPtr];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Storage array has no reset; only written words are ever read.
	always_ff @(posedge clk_sys)
	begin
		if (push)
			store[wrPtr] <= inData;
	end

	// Pointers and occupancy.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			if (pop)
				rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end

	property p_fifo_bound;
		@(posedge clk_sys) disable iff (!rstn)
		count <= DEPTH[AW:0];
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");
endmodule

module dpp_post_proc
	import dpp_pkg::*;
#(
	parameter int FIFO_DEPTH = 32
)(
	// Clock and reset.
	input  wire logic           clk_sys,
	input  wire logic           rstn,
	// APB slave.
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [11:0]    paddr,
	input  wire logic [31:0]    pwdata,
	output logic      [31:0]    prdata,
	output logic                pready,
	output logic                pslverr,
	// Samples from the audio interface.
	input  wire logic           sampleInValid,
	output logic                sampleInReady,
	input  wire dpp_sample_type sampleIn,
	// Samples and gains toward the modulators.
	output logic                sampleOutValid,
	input  wire logic           sampleOutReady,
	output dpp_sample_type      sampleOut,
	output logic [7:0]          gainLeft,
	output logic [7:0]          gainRight,
	output dpp_filter_type      filterSel,
	output logic [5:0]          outputOn
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic       silence;
	logic       unmuteRamp;
	logic       rampSpeed;
	logic       monoSum;
	logic       leftFlip;
	logic       rightFlip;
	logic [7:0] volPend [2];
	logic [7:0] volLive [2];
	logic [7:0] gain    [2];
	logic [4:0] tickCount;
	logic       rampTick;
	logic       fifoValid;
	logic       fifoPop;
	dpp_sample_type fifoData;
	logic       wrEn;
	logic       setupPh;
	logic [7:0] idx;

	assign idx     = paddr[9:2];
	assign wrEn    = psel && penable && pready && pwrite && !pslverr;
	assign setupPh = psel && !penable;

	function automatic logic mapped(input logic [7:0] i);
		mapped = (i == IDX_POWER_TWO) || (i == IDX_OUT_ENABLE) || (i == IDX_DAC_CTRL)
			|| (i == IDX_VOL_LEFT) || (i == IDX_VOL_RIGHT) || (i == IDX_SILENCE)
			|| (i == IDX_RAMP_FILT) || (i == IDX_LINE_L) || (i == IDX_LINE_R)
			|| (i == IDX_FIRST_L) || (i == IDX_FIRST_R) || (i == IDX_SECOND_L)
			|| (i == IDX_SECOND_R);
	endfunction

	// ----------------------------------------------------------------
	// APB answer: ready one cycle after setup, data from a flop
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
		else
		begin
			pready  <= setupPh;
			pslverr <= setupPh && (!mapped(idx) || paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0);
			prdata  <= 32'h0;
			if (setupPh && !pwrite && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0)
			begin
				unique case (idx)
					IDX_POWER_TWO:  prdata[5:4] <= outputOn[5:4];
					IDX_OUT_ENABLE: prdata[3:0] <= outputOn[3:0];
					IDX_DAC_CTRL:   prdata <= {18'h0, monoSum, 7'h0,
						filterSel.deemphasis, 2'h0, leftFlip, rightFlip};
					IDX_VOL_LEFT:   prdata[7:0] <= volPend[0];
					IDX_VOL_RIGHT:  prdata[7:0] <= volPend[1];
					IDX_SILENCE:    prdata[BIT_SILENCE] <= silence;
					IDX_RAMP_FILT:  prdata <= {17'h0, unmuteRamp, rampSpeed,
						filterSel.sloped, 12'h0};
					IDX_FIRST_L:    prdata[BIT_ALIAS] <= outputOn[0];
					IDX_FIRST_R:    prdata[BIT_ALIAS] <= outputOn[1];
					IDX_SECOND_L:   prdata[BIT_ALIAS] <= outputOn[2];
					IDX_SECOND_R:   prdata[BIT_ALIAS] <= outputOn[3];
					IDX_LINE_L:     prdata[BIT_ALIAS] <= outputOn[4];
					IDX_LINE_R:     prdata[BIT_ALIAS] <= outputOn[5];
					default:        prdata <= 32'h0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// Mute and mode bits; the mute starts set so the output is silent.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			silence              <= RST_SILENCE;
			unmuteRamp           <= 1'b0;
			rampSpeed            <= 1'b0;
			monoSum              <= 1'b0;
			leftFlip             <= 1'b0;
			rightFlip            <= 1'b0;
			filterSel.deemphasis <= RST_UNDO;
			filterSel.sloped     <= 1'b0;
		end
		else if (wrEn)
		begin
			if (idx == IDX_SILENCE)
				silence <= pwdata[BIT_SILENCE];
			if (idx == IDX_RAMP_FILT)
			begin
				unmuteRamp       <= pwdata[BIT_UNMUTE_RMP];
				rampSpeed        <= pwdata[BIT_RAMP_SPEED];
				filterSel.sloped <= pwdata[BIT_SLOPED];
			end
			if (idx == IDX_DAC_CTRL)
			begin
				monoSum              <= pwdata[BIT_MONO];
				filterSel.deemphasis <= pwdata[BIT_UNDO_LO+1:BIT_UNDO_LO];
				leftFlip             <= pwdata[BIT_LEFT_FLIP];
				rightFlip            <= pwdata[BIT_RIGHT_FLIP];
			end
		end
	end

	// One storage bit per output, written from either of its two homes.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			outputOn <= 6'h00;
		else if (wrEn)
		begin
			unique case (idx)
				IDX_OUT_ENABLE: outputOn[3:0] <= pwdata[3:0];
				IDX_POWER_TWO:  outputOn[5:4] <= pwdata[BIT_LINE_LO+1:BIT_LINE_LO];
				IDX_FIRST_L:    outputOn[0] <= pwdata[BIT_ALIAS];
				IDX_FIRST_R:    outputOn[1] <= pwdata[BIT_ALIAS];
				IDX_SECOND_L:   outputOn[2] <= pwdata[BIT_ALIAS];
				IDX_SECOND_R:   outputOn[3] <= pwdata[BIT_ALIAS];
				IDX_LINE_L:     outputOn[4] <= pwdata[BIT_ALIAS];
				IDX_LINE_R:     outputOn[5] <= pwdata[BIT_ALIAS];
				default:        outputOn <= outputOn;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Ramp tick: every two or thirty-two sample periods
	// ----------------------------------------------------------------
	// A full 192-step ramp at 48 kHz takes 8 ms or 128 ms, inside the limits.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			tickCount <= 5'h0;
		else if (fifoPop)
		begin
			if (rampTick)
				tickCount <= 5'h0;
			else
				tickCount <= tickCount + 5'h1;
		end
	end
	// A count left above the limit by a switch to fast speed ticks at once,
	// instead of waiting for the counter to wrap round.
	assign rampTick = fifoPop && (tickCount >= (rampSpeed ? 5'(RAMP_SLOW_PERIODS - 1)
		: 5'(RAMP_FAST_PERIODS - 1)));

	// ----------------------------------------------------------------
	// Per-channel volume holding and gain ramp
	// ----------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			// Pending code is what software wrote; live code is what is applied.
			always_ff @(posedge clk_sys or negedge rstn)
			begin
				if (!rstn)
				begin
					volPend[ch] <= RST_GAIN;
					volLive[ch] <= RST_GAIN;
				end
				else if (wrEn && (idx == IDX_VOL_LEFT || idx == IDX_VOL_RIGHT))
				begin
					if (idx == (ch == 0 ? IDX_VOL_LEFT : IDX_VOL_RIGHT))
						volPend[ch] <= pwdata[7:0];
					if (pwdata[BIT_APPLY])
						volLive[ch] <= (idx == (ch == 0 ? IDX_VOL_LEFT : IDX_VOL_RIGHT))
							? pwdata[7:0] : volPend[ch];
				end
			end

			// The ramp always moves from where the gain stands now, so a mute
			// arriving mid-ramp simply turns it round without a click.
			always_ff @(posedge clk_sys or negedge rstn)
			begin
				if (!rstn)
					gain[ch] <= 8'h00;
				else if (silence)
				begin
					if (rampTick && gain[ch] != 8'h00)
						gain[ch] <= gain[ch] - 8'h01;
				end
				else if (!unmuteRamp)
					gain[ch] <= volLive[ch];
				else if (rampTick && gain[ch] < volLive[ch])
					gain[ch] <= gain[ch] + 8'h01;
				else if (rampTick && gain[ch] > volLive[ch])
					gain[ch] <= gain[ch] - 8'h01;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Sample path: FIFO, mono sum, polarity
	// ----------------------------------------------------------------
	dpp_fifo #(
		.WIDTH ($bits(dpp_sample_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.inValid  (sampleInValid),
		.inReady  (sampleInReady),
		.inData   (sampleIn),
		.outValid (fifoValid),
		.outReady (!sampleOutValid || sampleOutReady),
		.outData  (fifoData)
	);
	assign fifoPop = fifoValid && (!sampleOutValid || sampleOutReady);

	// Negation of the most negative 24-bit value saturates instead of wrapping.
	function automatic logic signed [23:0] flip(input logic signed [23:0] x,
		input logic en);
		if (!en)
			flip = x;
		else if (x == 24'sh800000)
			flip = 24'sh7fffff;
		else
			flip = -x;
	endfunction

	logic signed [24:0] monoWide;
	logic signed [23:0] srcLeft;
	logic signed [23:0] srcRight;
	assign monoWide = {fifoData.left[23], fifoData.left}
		+ {fifoData.right[23], fifoData.right};
	assign srcLeft  = monoSum ? monoWide[24:1] : fifoData.left;
	assign srcRight = monoSum ? monoWide[24:1] : fifoData.right;

	// Output stage holds one sample with the gain in force when it left.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			sampleOutValid <= 1'b0;
			sampleOut      <= '0;
			gainLeft       <= 8'h00;
			gainRight      <= 8'h00;
		end
		else
		begin
			if (fifoPop)
			begin
				sampleOut.left  <= flip(srcLeft, leftFlip);
				sampleOut.right <= flip(srcRight, rightFlip);
				gainLeft        <= gain[0];
				gainRight       <= gain[1];
				sampleOutValid  <= 1'b1;
			end
			else if (sampleOutReady)
				sampleOutValid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_mute_step;
		@(posedge clk_sys) disable iff (!rstn)
		(silence && rampTick && gain[0] != 8'h00) |=> gain[0] == $past(gain[0]) - 8'h01;
	endproperty
	a_mute_step: assert property (p_mute_step) else $error("mute step wrong");

	property p_mute_floor;
		@(posedge clk_sys) disable iff (!rstn)
		(silence && gain[1] == 8'h00) |=> gain[1] == 8'h00;
	endproperty
	a_mute_floor: assert property (p_mute_floor) else $error("gain left silence");

	property p_jump;
		@(posedge clk_sys) disable iff (!rstn)
		(!silence && !unmuteRamp) ##1 (!silence && !unmuteRamp) |-> gain[0] == $past(volLive[0]);
	endproperty
	a_jump: assert property (p_jump) else $error("instant unmute wrong");

	property p_ramp_up;
		@(posedge clk_sys) disable iff (!rstn)
		(!silence && unmuteRamp && !rampTick) |=> gain[1] == $past(gain[1]);
	endproperty
	a_ramp_up: assert property (p_ramp_up) else $error("gain moved off tick");

	property p_tick_gap;
		@(posedge clk_sys) disable iff (!rstn)
		(rampTick && !rampSpeed) |=> tickCount == 5'h0 && !rampTick;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("fast tick spacing");

	property p_alias;
		@(posedge clk_sys) disable iff (!rstn)
		(wrEn && idx == IDX_FIRST_R) |=> outputOn[1] == $past(pwdata[BIT_ALIAS]);
	endproperty
	a_alias: assert property (p_alias) else $error("alias write lost");

	property p_mono;
		@(posedge clk_sys) disable iff (!rstn)
		(fifoPop && monoSum && !leftFlip && !rightFlip) |=> sampleOut.left == sampleOut.right;
	endproperty
	a_mono: assert property (p_mono) else $error("mono channels differ");

	property p_flip;
		@(posedge clk_sys) disable iff (!rstn)
		(fifoPop && !monoSum && leftFlip && fifoData.left != 24'sh800000)
		|=> sampleOut.left == -$past(fifoData.left);
	endproperty
	a_flip: assert property (p_flip) else $error("left not inverted");

	property p_apply;
		@(posedge clk_sys) disable iff (!rstn)
		(wrEn && idx == IDX_VOL_LEFT && !pwdata[BIT_APPLY]) |=> $stable(volLive[0]);
	endproperty
	a_apply: assert property (p_apply) else $error("gain applied without strobe");

	property p_ready;
		@(posedge clk_sys) disable iff (!rstn)
		setupPh |=> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready) else $error("apb ready timing");

	c_unmute_ramp: cover property (@(posedge clk_sys) disable iff (!rstn)
		!silence && unmuteRamp && rampTick && gain[0] < volLive[0]);
	c_reverse: cover property (@(posedge clk_sys) disable iff (!rstn)
		$rose(silence) && gain[0] != 8'h00 && gain[0] < volLive[0]);
	c_fifo_full: cover property (@(posedge clk_sys) disable iff (!rstn)
		sampleInValid && !sampleInReady);
endmodule

/* File: dpp_pkg.sv */
// Purpose: Shared constants and types for the playback post-processing block.
// Assumes: Register index times four gives the APB byte address.
// Notes:   Sample periods are counted by samples accepted from the FIFO.
package dpp_pkg;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_POWER_TWO  = 8'h09;
	localparam logic [7:0] IDX_OUT_ENABLE = 8'h0a;
	localparam logic [7:0] IDX_DAC_CTRL   = 8'h30;
	localparam logic [7:0] IDX_VOL_LEFT   = 8'h32;
	localparam logic [7:0] IDX_VOL_RIGHT  = 8'h33;
	localparam logic [7:0] IDX_SILENCE    = 8'h3a;
	localparam logic [7:0] IDX_RAMP_FILT  = 8'h3b;
	localparam logic [7:0] IDX_LINE_L     = 8'h5c;
	localparam logic [7:0] IDX_LINE_R     = 8'h5d;
	localparam logic [7:0] IDX_FIRST_L    = 8'h68;
	localparam logic [7:0] IDX_FIRST_R    = 8'h69;
	localparam logic [7:0] IDX_SECOND_L   = 8'h70;
	localparam logic [7:0] IDX_SECOND_R   = 8'h71;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int BIT_SILENCE    = 14;
	localparam int BIT_UNMUTE_RMP = 14;
	localparam int BIT_RAMP_SPEED = 13;
	localparam int BIT_SLOPED     = 12;
	localparam int BIT_MONO       = 13;
	localparam int BIT_UNDO_LO    = 4;
	localparam int BIT_LEFT_FLIP  = 1;
	localparam int BIT_RIGHT_FLIP = 0;
	localparam int BIT_APPLY      = 8;
	localparam int BIT_ALIAS      = 15;
	localparam int BIT_LINE_LO    = 4;
	localparam logic       RST_SILENCE = 1'b1;
	localparam logic [7:0] RST_GAIN    = 8'hc0;
	localparam logic [1:0] RST_UNDO    = 2'h0;

	// ----------------------------------------------------------------
	// Ramp timing, in sample periods and milliseconds
	// ----------------------------------------------------------------
	localparam int   RAMP_FAST_PERIODS = 2;
	localparam int   RAMP_SLOW_PERIODS = 32;
	localparam real  RAMP_FAST_MS      = 10.7;
	localparam real  RAMP_SLOW_MS      = 171.0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic signed [23:0] left;
		logic signed [23:0] right;
	} dpp_sample_type;

	typedef struct packed {
		logic [1:0] deemphasis;
		logic       sloped;
	} dpp_filter_type;

endpackage

/* File: dpp_sink_model.sv */
// Purpose: Stand-in for the modulators that take processed samples.
// Assumes: The block holds its sample until ready is seen high.
// Notes:   Slow mode takes one sample in three cycles; stall takes none.
`timescale 1ns/1ps

module dpp_sink_model (
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Pacing chosen by the bench.
	input  wire logic stall,
	input  wire logic slow,
	// Handshake toward the block.
	output logic      sampleOutReady
);
	logic [1:0] phase;

	// ----------------------------------------------------------------
	// Pacing
	// ----------------------------------------------------------------
	// The modulator runs on its own beat, unrelated to the upstream rate.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			phase <= 2'h0;
		else
			phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
	end

	// A stalled modulator lets the buffer fill, which is what we want to see.
	assign sampleOutReady = !stall && (!slow || phase == 2'h0);
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the playback post-processing block.
// Assumes: Zero-wait APB slave; one stereo sample per period.
// Notes:   Small gain codes keep the mute and unmute ramps short.
`timescale 1ns/1ps

module testbench
	import dpp_pkg::*;
;
	typedef struct packed {
		logic [7:0]     idxW;
		logic [15:0]    wdata;
		logic [7:0]     idxR;
		logic [15:0]    expRead;
		dpp_sample_type sIn;
		dpp_sample_type sExp;
		logic [2:0]     expFilt;
		logic [5:0]     expOn;
	} dpp_row_type;

	logic           clk_sys       = 1'b0;
	logic           rstn          = 1'b0;
	logic           psel          = 1'b0;
	logic           penable       = 1'b0;
	logic           pwrite        = 1'b0;
	logic [11:0]    paddr         = 12'h0;
	logic [31:0]    pwdata        = 32'h0;
	logic           sampleInValid = 1'b0;
	dpp_sample_type sampleIn      = 48'h0;
	logic           stall         = 1'b0;
	logic           slow          = 1'b0;
	logic [31:0]    prdata, rdata;
	logic           pready, pslverr, slvErr, ok;
	logic           sampleInReady, sampleOutValid, sampleOutReady;
	dpp_sample_type sampleOut, gotS;
	dpp_filter_type filterSel;
	logic [7:0]     gainLeft, gainRight;
	logic [7:0]     gotL = 8'h0;
	logic [7:0]     gotR = 8'h0;
	logic [5:0]     outputOn;
	dpp_sample_type outQ[$];
	logic [15:0]    gainQ[$];
	int             n_errors = 0;
	int             n_tests  = 0;
	int             cnt;
	logic [7:0]     rstIdx[8] = '{IDX_SILENCE, IDX_VOL_LEFT, IDX_VOL_RIGHT, IDX_DAC_CTRL,
		IDX_RAMP_FILT, IDX_OUT_ENABLE, IDX_POWER_TWO, IDX_FIRST_L};
	logic [15:0]    rstVal[8] = '{16'h4000, 16'hc0, 16'hc0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
	// Mono rows take both DAC enables, which sit outside this block, as on.
	dpp_row_type    rows[12] = '{
	'{IDX_DAC_CTRL, 16'h30, IDX_DAC_CTRL, 16'h30, 48'h000005_000007, 48'h000005_000007, 3'h6, 6'h0},
	'{IDX_DAC_CTRL, 16'h20, IDX_DAC_CTRL, 16'h20, 48'h800000_7fffff, 48'h800000_7fffff, 3'h4, 6'h0},
	'{IDX_DAC_CTRL, 16'h13, IDX_DAC_CTRL, 16'h13, 48'h123456_fffffb, 48'hedcbaa_000005, 3'h2, 6'h0},
	'{IDX_DAC_CTRL, 16'h2000, IDX_DAC_CTRL, 16'h2000, 48'h000064_00012c, 48'h0000c8_0000c8, 3'h0,
		6'h0},
	'{IDX_DAC_CTRL, 16'h2002, IDX_DAC_CTRL, 16'h2002, 48'hfffffd_000000, 48'h000002_fffffe, 3'h0,
		6'h0},
	'{IDX_DAC_CTRL, 16'h1, IDX_DAC_CTRL, 16'h1, 48'h000010_800000, 48'h000010_7fffff, 3'h0, 6'h0},
	'{IDX_RAMP_FILT, 16'h1000, IDX_RAMP_FILT, 16'h1000, 48'h000001_000000, 48'h000001_000000, 3'h1,
		6'h0},
	'{IDX_OUT_ENABLE, 16'h5, IDX_FIRST_L, 16'h8000, 48'h0, 48'h0, 3'h1, 6'h05},
	'{IDX_SECOND_R, 16'h8000, IDX_OUT_ENABLE, 16'hd, 48'h0, 48'h0, 3'h1, 6'h0d},
	'{IDX_POWER_TWO, 16'h30, IDX_LINE_R, 16'h8000, 48'h0, 48'h0, 3'h1, 6'h3d},
	'{IDX_LINE_L, 16'h0, IDX_POWER_TWO, 16'h20, 48'h0, 48'h0, 3'h1, 6'h2d},
	'{IDX_FIRST_R, 16'h8000, IDX_OUT_ENABLE, 16'hf, 48'h0, 48'h0, 3'h1, 6'h2f}};

	// ----------------------------------------------------------------
	// Clock, design and partner
	// ----------------------------------------------------------------
	// Free-running 100 MHz clock.
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end

	dpp_post_proc #(.FIFO_DEPTH(32)) u_dpp_post_proc (.clk_sys(clk_sys), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sampleInValid(sampleInValid),
		.sampleInReady(sampleInReady), .sampleIn(sampleIn), .sampleOutValid(sampleOutValid),
		.sampleOutReady(sampleOutReady), .sampleOut(sampleOut), .gainLeft(gainLeft),
		.gainRight(gainRight), .filterSel(filterSel), .outputOn(outputOn));

	dpp_sink_model u_dpp_sink_model (.clk_sys(clk_sys), .rstn(rstn), .stall(stall),
		.slow(slow), .sampleOutReady(sampleOutReady));

	// Every accepted output sample is queued with the gains that went with it.
	always @(posedge clk_sys)
	begin
		if (sampleOutValid === 1'b1 && sampleOutReady === 1'b1)
		begin
			outQ.push_back(sampleOut);
			gainQ.push_back({gainLeft, gainRight});
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("counts: %0d compares, %0d mismatches", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL t=%0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic giveUp(input string what);
		n_errors++;
		$display("FAIL t=%0t %s timed out", $time, what);
		summarize();
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
		int k;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= {16'h0, wd};
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
			giveUp("apb");
		rdata  = prdata;
		slvErr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Offers one sample for up to lim edges; ok tells whether it was taken.
	task automatic push(input logic [47:0] s, input int lim);
		int k;
		@(posedge clk_sys);
		sampleInValid <= 1'b1;
		sampleIn      <= s;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (sampleInReady !== 1'b1 && k < lim);
		ok = (sampleInReady === 1'b1);
		sampleInValid <= 1'b0;
	endtask

	task automatic pull();
		int k;
		k = 0;
		while (outQ.size() == 0 && k < 300)
		begin
			@(posedge clk_sys);
			k++;
		end
		if (outQ.size() == 0)
			giveUp("pull");
		gotS = outQ.pop_front();
		{gotL, gotR} = gainQ.pop_front();
	endtask

	task automatic xfer(input logic [47:0] s);
		push(s, 200);
		if (!ok)
			giveUp("push");
		pull();
	endtask

	// Runs n silent samples; each gain may move by one code only, in direction dir.
	task automatic ramp(input int n, input int dir);
		logic [7:0] pl, pr, dl, dr;
		for (int i = 0; i < n; i++)
		begin
			pl = gotL;
			pr = gotR;
			xfer(48'h0);
			dl = (dir > 0) ? gotL - pl : pl - gotL;
			dr = (dir > 0) ? gotR - pr : pr - gotR;
			check((dl > 8'h1 || dr > 8'h1) ? 48'h1 : 48'h0, 48'h0, "gain step");
		end
	endtask

	task automatic doReset();
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		outQ.delete();
		gainQ.delete();
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		doReset();
		// Releasing the mute in jump mode lets every row expect full gain.
		apb(1'b1, IDX_SILENCE, 16'h0);
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].idxW, rows[i].wdata);
			apb(1'b0, rows[i].idxR, 16'h0);
			check(rdata, rows[i].expRead, "readback");
			check(filterSel, rows[i].expFilt, "filter");
			check(outputOn, rows[i].expOn, "enables");
			xfer(rows[i].sIn);
			check(gotS, rows[i].sExp, "sample");
			check({gotL, gotR}, 16'hc0c0, "gain");
		end
		$display("test table done");

		// A second reset in mid-run must restore every default.
		doReset();
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b0, rstIdx[i], 16'h0);
			check(rdata, rstVal[i], "reset value");
		end
		check(outputOn, 6'h0, "reset enables");
		apb(1'b0, 8'h01, 16'h0);
		check({slvErr, rdata}, 33'h100000000, "unmapped");
		$display("test reset done");

		// New codes wait for the apply strobe, then both move together.
		apb(1'b1, IDX_VOL_LEFT, 16'h8);
		apb(1'b1, IDX_SILENCE, 16'h0);
		xfer(48'h0);
		check({gotL, gotR}, 16'hc0c0, "no apply");
		apb(1'b1, IDX_VOL_RIGHT, 16'h10c);
		xfer(48'h0);
		check({gotL, gotR}, 16'h080c, "apply");
		// Fast mute: one code per two samples, ending exactly at silence.
		apb(1'b1, IDX_SILENCE, 16'h4000);
		ramp(10, -1);
		check((gotR >= 8'h6 && gotR <= 8'h8) ? 48'h1 : 48'h0, 48'h1, "fast rate");
		ramp(20, -1);
		check({gotL, gotR}, 16'h0, "silence");
		// Slow ramped unmute, then a mute that must turn back from where it is.
		apb(1'b1, IDX_RAMP_FILT, 16'h6000);
		apb(1'b1, IDX_SILENCE, 16'h0);
		ramp(40, 1);
		check((gotR >= 8'h1 && gotR <= 8'h2) ? 48'h1 : 48'h0, 48'h1, "slow rate");
		apb(1'b1, IDX_RAMP_FILT, 16'h4000);
		apb(1'b1, IDX_SILENCE, 16'h4000);
		ramp(8, -1);
		check({gotL, gotR}, 16'h0, "reversed");
		$display("test ramp done");

		// Stalled modulator: fill the buffer until it refuses, then drain in order.
		stall <= 1'b1;
		cnt = 0;
		do
		begin
			push({24'(cnt), 24'h0}, 4);
			if (ok)
				cnt++;
		end
		while (ok && cnt < 40);
		check((cnt == 32 || cnt == 33) ? 48'h1 : 48'h0, 48'h1, "fill depth");
		slow  <= 1'b1;
		stall <= 1'b0;
		for (int i = 0; i < cnt; i++)
		begin
			pull();
			check(gotS.left, 24'(i), "order");
		end
		check(sampleInReady, 1'b1, "drained");
		$display("test buffer done");
		summarize();
	end
endmodule
